// ### hw/dbt_pkg.sv
package dbt_pkg;
    localparam int          NCH          = 4;
    localparam int          SEL_W        = 5;
    localparam int          NSRC         = 32;
    localparam int          CHR_W        = 18;
    // Register byte offsets; channel n sits at OFS_CH0 + 4*n.
    localparam logic [5:0]  OFS_CH0      = 6'h00;
    localparam logic [5:0]  OFS_CFG      = 6'h10;
    localparam logic [5:0]  OFS_EXTCYC   = 6'h14;
    localparam logic [5:0]  OFS_STAT     = 6'h18;
    // Channel register fields.
    localparam int          F_SEL        = 0;
    localparam int          F_SWREQ      = 5;
    localparam int          F_WIDTH      = 6;
    localparam int          F_EN         = 7;
    localparam int          F_SRC_CLS    = 8;
    localparam int          F_SRC_REG    = 10;
    localparam int          F_SRC_ODD    = 12;
    localparam int          F_DST_CLS    = 13;
    localparam int          F_DST_REG    = 15;
    localparam int          F_DST_ODD    = 17;
    // Configuration register fields.
    localparam int          F_EXTMODE    = 0;
    localparam int          F_BW         = 4;
    localparam int          F_RCV        = 8;
    localparam int          CFG_W        = 12;
    localparam int          EXT_W        = 16;
    localparam logic [11:0] CFG_RST      = 12'h0F0;
    localparam logic [15:0] EXTCYC_RST   = 16'h2222;
    // Cycle coefficients.
    localparam logic [3:0]  COEF_RAM     = 4'h1;
    localparam logic [3:0]  COEF_RAM_WS  = 4'h2;
    localparam logic [3:0]  COEF_SFR     = 4'h2;
    localparam logic [3:0]  EXT_MIN      = 4'h2;
    localparam logic [3:0]  EXT_MAX      = 4'h9;

    typedef enum logic [1:0] {
        CLS_RAM    = 2'b00,
        CLS_RAM_WS = 2'b01,
        CLS_SFR    = 2'b10,
        CLS_EXT    = 2'b11
    } dbt_cls_e;

    typedef enum logic [1:0] {
        ST_IDLE     = 2'b00,
        ST_READ     = 2'b01,
        ST_WRITE    = 2'b11,
        ST_HANDBACK = 2'b10
    } dbt_state_e;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [5:0]  address;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } dbt_avs_s;

    typedef struct packed {
        logic       own;
        logic       wr;
        logic [1:0] ch;
        logic       word;
        logic       second;
    } dbt_bus_s;
endpackage : dbt_pkg

// ### hw/dbt_cycle_calc.sv
`timescale 1ns/100ps
module dbt_cycle_calc
    import dbt_pkg::*;
(
    input  wire logic        i_word,
    input  wire logic        i_odd,
    input  wire logic [1:0]  i_cls,
    input  wire logic [1:0]  i_region,
    input  wire logic        i_ext_mode,
    input  wire logic [3:0]  i_bus_width,
    input  wire logic [15:0] i_ext_cyc,
    input  wire logic [3:0]  i_recovery,
    output logic [1:0]       o_nbus,
    output logic [3:0]       o_coef,
    output logic             o_ext
);
    logic       ext;
    logic       narrow;
    logic [3:0] cyc;

    always_comb begin
        // External class is honoured only in the external-bus mode.
        ext    = i_ext_mode && (i_cls == CLS_EXT);
        narrow = ext && !i_bus_width[i_region];
        cyc    = i_ext_cyc[4*i_region +: 4];
        if (cyc < EXT_MIN) begin
            cyc = EXT_MIN;
        end else if (cyc > EXT_MAX) begin
            cyc = EXT_MAX;
        end
        if (!i_word) begin
            o_nbus = 2'd1;
        end else if (i_odd || narrow) begin
            o_nbus = 2'd2;
        end else begin
            o_nbus = 2'd1;
        end
        if (ext) begin
            o_coef = cyc + {3'd0, i_recovery[i_region]};
        end else if (i_cls == CLS_RAM) begin
            o_coef = COEF_RAM;
        end else if (i_cls == CLS_RAM_WS) begin
            o_coef = COEF_RAM_WS;
        end else begin
            o_coef = COEF_SFR;
        end
        o_ext = ext;
    end
endmodule : dbt_cycle_calc

// ### hw/dbt_req_flags.sv
`timescale 1ns/100ps
module dbt_req_flags
    import dbt_pkg::*;
(
    input  wire logic                      i_clk,
    input  wire logic                      i_rst,
    input  wire logic                      i_ce,
    input  wire logic [NCH-1:0][SEL_W-1:0] i_src_sel,
    input  wire logic [NCH-1:0]            i_enable,
    input  wire logic [NCH-1:0]            i_sw_req,
    input  wire logic [NSRC-1:0]           i_periph_irq,
    input  wire logic [NCH-1:0]            i_grant,
    output logic [NCH-1:0]                 o_pending,
    output logic [NCH-1:0]                 o_raw
);
    typedef struct packed {
        logic [NCH-1:0] flag;
    } dbt_req_s;

    dbt_req_s st_reg;
    dbt_req_s st_next;

    always_comb begin
        st_next = st_reg;
        for (int c = 0; c < NCH; c++) begin
            // Select zero means software trigger only.
            o_raw[c] = i_enable[c] && (i_sw_req[c] ||
                       ((i_src_sel[c] != '0) && i_periph_irq[i_src_sel[c]]));
            if (i_grant[c]) begin
                st_next.flag[c] = 1'b0;
            end
            if (o_raw[c]) begin
                st_next.flag[c] = 1'b1;
            end
        end
        o_pending = st_reg.flag;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_reg <= '0;
        end else if (i_ce) begin
            st_reg <= st_next;
        end
    end
endmodule : dbt_req_flags

// ### hw/dbt_top.sv
`timescale 1ns/100ps
module dbt_top
    import dbt_pkg::*;
(
    input  wire logic            i_clk,
    input  wire logic            i_rst,
    input  wire logic            i_ce,
    input  wire dbt_avs_s        i_avs,
    output logic                 o_avs_waitrequest,
    output logic [31:0]          o_avs_readdata,
    input  wire logic [NSRC-1:0] i_periph_irq,
    input  wire logic            i_wait_req,
    input  wire logic            i_cpu_done,
    output dbt_bus_s             o_bus,
    output logic                 o_cpu_owns_bus
);
    typedef struct packed {
        dbt_state_e                st;
        logic [1:0]                ch;
        logic [3:0]                cnt;
        logic [1:0]                nbus;
        logic                      second;
        logic [7:0]                tot;
        logic [7:0]                last;
        logic [7:0]                expect_tot;
        logic [NCH-1:0][CHR_W-1:0] chr;
        logic [CFG_W-1:0]          cfg;
        logic [EXT_W-1:0]          extc;
        logic [NCH-1:0]            swreq;
        logic                      ack;
        logic [31:0]               rdata;
    } dbt_top_s;

    dbt_top_s                  st_reg;
    dbt_top_s                  st_next;
    logic [NCH-1:0]            pending;
    logic [NCH-1:0]            raw;
    logic [NCH-1:0]            grant;
    logic [NCH-1:0]            enable;
    logic [NCH-1:0][SEL_W-1:0] src_sel;
    logic [1:0]                pick;
    logic [1:0]                sel_ch;
    logic [CHR_W-1:0]          cur;
    logic [1:0]                src_n;
    logic [1:0]                dst_n;
    logic [3:0]                src_k;
    logic [3:0]                dst_k;
    logic                      src_ext;
    logic                      dst_ext;
    logic                      stall;
    logic                      req;
    logic                      acc;

    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction : be_merge

    function automatic logic [7:0] cyc_mul(input logic [1:0] n, input logic [3:0] k);
        return (n == 2'd2) ? {3'd0, k, 1'b0} : {4'd0, k};
    endfunction : cyc_mul

    always_comb begin
        pick = 2'd3;
        for (int c = NCH - 1; c >= 0; c--) begin
            if (pending[c]) begin
                pick = c[1:0];
            end
        end
        for (int c = 0; c < NCH; c++) begin
            enable[c]  = st_reg.chr[c][F_EN];
            src_sel[c] = st_reg.chr[c][F_SEL +: SEL_W];
        end
        sel_ch = (st_reg.st == ST_IDLE) ? pick : st_reg.ch;
        cur    = st_reg.chr[sel_ch];
    end

    dbt_req_flags u_req (
        .i_clk        (i_clk),
        .i_rst        (i_rst),
        .i_ce         (i_ce),
        .i_src_sel    (src_sel),
        .i_enable     (enable),
        .i_sw_req     (st_reg.swreq),
        .i_periph_irq (i_periph_irq),
        .i_grant      (grant),
        .o_pending    (pending),
        .o_raw        (raw)
    );

    dbt_cycle_calc u_src (
        .i_word      (cur[F_WIDTH]),
        .i_odd       (cur[F_SRC_ODD]),
        .i_cls       (cur[F_SRC_CLS +: 2]),
        .i_region    (cur[F_SRC_REG +: 2]),
        .i_ext_mode  (st_reg.cfg[F_EXTMODE]),
        .i_bus_width (st_reg.cfg[F_BW +: 4]),
        .i_ext_cyc   (st_reg.extc),
        .i_recovery  (st_reg.cfg[F_RCV +: 4]),
        .o_nbus      (src_n),
        .o_coef      (src_k),
        .o_ext       (src_ext)
    );

    dbt_cycle_calc u_dst (
        .i_word      (cur[F_WIDTH]),
        .i_odd       (cur[F_DST_ODD]),
        .i_cls       (cur[F_DST_CLS +: 2]),
        .i_region    (cur[F_DST_REG +: 2]),
        .i_ext_mode  (st_reg.cfg[F_EXTMODE]),
        .i_bus_width (st_reg.cfg[F_BW +: 4]),
        .i_ext_cyc   (st_reg.extc),
        .i_recovery  (st_reg.cfg[F_RCV +: 4]),
        .o_nbus      (dst_n),
        .o_coef      (dst_k),
        .o_ext       (dst_ext)
    );

    always_comb begin
        st_next       = st_reg;
        st_next.swreq = '0;
        grant         = '0;
        req           = i_avs.read || i_avs.write;
        acc           = req && st_reg.ack;
        stall         = i_wait_req && (((st_reg.st == ST_READ) && src_ext) ||
                                       ((st_reg.st == ST_WRITE) && dst_ext));
        // Register access: one wait cycle, answer on the second.
        st_next.ack = req && !st_reg.ack;
        if (req && !st_reg.ack) begin
            if (i_avs.address[5:4] == OFS_CH0[5:4]) begin
                st_next.rdata = {{(32-CHR_W){1'b0}}, st_reg.chr[i_avs.address[3:2]]};
                st_next.rdata[F_SWREQ] = 1'b0;
            end else if (i_avs.address == OFS_CFG) begin
                st_next.rdata = {{(32-CFG_W){1'b0}}, st_reg.cfg};
            end else if (i_avs.address == OFS_EXTCYC) begin
                st_next.rdata = {{(32-EXT_W){1'b0}}, st_reg.extc};
            end else if (i_avs.address == OFS_STAT) begin
                st_next.rdata = {16'h0000, st_reg.last, st_reg.st, st_reg.ch, pending};
            end else begin
                st_next.rdata = 32'h0000_0000;
            end
        end
        if (acc && i_avs.write) begin
            if (i_avs.address[5:4] == OFS_CH0[5:4]) begin
                st_next.chr[i_avs.address[3:2]] = CHR_W'(be_merge(
                    {{(32-CHR_W){1'b0}}, st_reg.chr[i_avs.address[3:2]]},
                    i_avs.writedata, i_avs.byteenable));
                st_next.chr[i_avs.address[3:2]][F_SWREQ] = 1'b0;
                st_next.swreq[i_avs.address[3:2]] = i_avs.byteenable[0] &&
                                                    i_avs.writedata[F_SWREQ];
            end else if (i_avs.address == OFS_CFG) begin
                st_next.cfg = CFG_W'(be_merge({{(32-CFG_W){1'b0}}, st_reg.cfg},
                                              i_avs.writedata, i_avs.byteenable));
            end else if (i_avs.address == OFS_EXTCYC) begin
                st_next.extc = EXT_W'(be_merge({{(32-EXT_W){1'b0}}, st_reg.extc},
                                               i_avs.writedata, i_avs.byteenable));
            end
        end
        // Transfer sequencer.
        case (st_reg.st)
            ST_IDLE: begin
                if (|pending) begin
                    grant[pick]        = 1'b1;
                    st_next.st         = ST_READ;
                    st_next.ch         = pick;
                    st_next.nbus       = src_n;
                    st_next.cnt        = src_k;
                    st_next.second     = 1'b0;
                    st_next.tot        = 8'd0;
                    st_next.expect_tot = cyc_mul(src_n, src_k) + cyc_mul(dst_n, dst_k);
                end
            end
            ST_READ, ST_WRITE: begin
                if (!stall) begin
                    st_next.tot = st_reg.tot + 8'd1;
                    if (st_reg.cnt > 4'd1) begin
                        st_next.cnt = st_reg.cnt - 4'd1;
                    end else if (st_reg.nbus > 2'd1) begin
                        st_next.nbus   = st_reg.nbus - 2'd1;
                        st_next.second = 1'b1;
                        st_next.cnt    = (st_reg.st == ST_READ) ? src_k : dst_k;
                    end else if (st_reg.st == ST_READ) begin
                        st_next.st     = ST_WRITE;
                        st_next.nbus   = dst_n;
                        st_next.cnt    = dst_k;
                        st_next.second = 1'b0;
                    end else begin
                        st_next.st   = ST_HANDBACK;
                        st_next.last = st_reg.tot + 8'd1;
                    end
                end
            end
            default: begin
                if (i_cpu_done || !(|pending)) begin
                    st_next.st = ST_IDLE;
                end
            end
        endcase
        o_avs_waitrequest = req && !(st_reg.ack && i_ce);
        o_avs_readdata    = st_reg.rdata;
        o_bus.own         = (st_reg.st == ST_READ) || (st_reg.st == ST_WRITE);
        o_bus.wr          = (st_reg.st == ST_WRITE);
        o_bus.ch          = st_reg.ch;
        o_bus.word        = cur[F_WIDTH] &&
                            (((st_reg.st == ST_READ) ? src_n : dst_n) == 2'd1);
        o_bus.second      = st_reg.second;
        o_cpu_owns_bus    = !o_bus.own;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_reg      <= '0;
            st_reg.cfg  <= CFG_RST;
            st_reg.extc <= EXTCYC_RST;
        end else if (i_ce) begin
            st_reg <= st_next;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    a_idle_no_req: assert property ((st_reg.st == ST_IDLE) && !(|pending) && i_ce
                                    |=> st_reg.st == ST_IDLE && o_cpu_owns_bus)
        else $error("Bus left the CPU with no pending request.");
    a_prio_zero: assert property ((st_reg.st == ST_IDLE) && pending[0] && i_ce
                                  |=> st_reg.st == ST_READ && st_reg.ch == 2'd0)
        else $error("Channel zero not served first.");
    a_flag_clear: assert property ((st_reg.st == ST_IDLE) && pending[0] && i_ce
                                   && !raw[0] |=> !pending[0])
        else $error("Pending flag not cleared on grant.");
    a_flag_set: assert property (raw[1] && i_ce |=> pending[1])
        else $error("Request did not set its flag.");
    a_byte_single: assert property ((st_reg.st == ST_IDLE) && (|pending) && i_ce
                                    && !cur[F_WIDTH] |=> st_reg.nbus == 2'd1)
        else $error("Byte transfer read used more than one bus cycle.");
    a_odd_word: assert property ((st_reg.st == ST_IDLE) && (|pending) && i_ce
                                 && cur[F_WIDTH] && cur[F_SRC_ODD] |=> st_reg.nbus == 2'd2)
        else $error("Odd word read did not take two bus cycles.");
    a_read_first: assert property ($rose(st_reg.st == ST_WRITE)
                                  |-> $past(st_reg.st) == ST_READ)
        else $error("Write phase entered without a read phase.");
    a_wait_stretch: assert property (o_bus.own && stall && i_ce
                                     |=> $stable(st_reg.cnt) && $stable(st_reg.st))
        else $error("Cycle advanced while wait request was active.");
    a_total_cycles: assert property ($rose(st_reg.st == ST_HANDBACK)
                                     |-> st_reg.last == st_reg.expect_tot)
        else $error("Transfer cycle count differs from j and k formula.");
    a_handback_hold: assert property ((st_reg.st == ST_HANDBACK) && !i_cpu_done
                                      && (|pending) |=> st_reg.st == ST_HANDBACK)
        else $error("Next transfer started before a CPU access.");

    c_byte_xfer: cover property ((st_reg.st == ST_WRITE) && !cur[F_WIDTH]
                                 ##1 st_reg.st == ST_HANDBACK);
    c_odd_word: cover property ((st_reg.st == ST_READ) && st_reg.second);
    c_stretch: cover property ((o_bus.own && stall) [*2]);
    c_two_ch: cover property ((st_reg.st == ST_HANDBACK) && (|pending) && i_cpu_done);
endmodule : dbt_top

// ### bench/dbt_cpu_model.sv
`timescale 1ns/100ps
module dbt_cpu_model
    import dbt_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire dbt_bus_s   i_bus,
    input  wire logic       i_cpu_owns_bus,
    input  wire logic [3:0] i_stall,
    input  wire logic [3:0] i_cpu_len,
    output logic            o_cpu_done,
    output logic            o_wait_req
);
    logic [3:0] own_cnt_reg;
    logic [3:0] cpu_cnt_reg;
    always_ff @(posedge i_clk) begin
        if (i_rst || !i_bus.own) own_cnt_reg <= 4'h0;
        else if (own_cnt_reg != 4'hF) own_cnt_reg <= own_cnt_reg + 4'h1;
        if (i_rst || !i_cpu_owns_bus) cpu_cnt_reg <= 4'h0;
        else if (cpu_cnt_reg != 4'hF) cpu_cnt_reg <= cpu_cnt_reg + 4'h1;
    end
    // The external device holds wait for the first cycles of each steal.
    assign o_wait_req = i_bus.own && (own_cnt_reg < i_stall);
    // The CPU finishes one access a set time after it gets the bus back.
    assign o_cpu_done = i_cpu_owns_bus && (cpu_cnt_reg == i_cpu_len);
endmodule : dbt_cpu_model

// ### bench/dbt_top_test.sv
`timescale 1ns/100ps
module dbt_top_test
    import dbt_pkg::*;
;
    typedef struct packed {
        logic [31:0] ch;
        logic [11:0] cfg;
        logic [15:0] ext;
        logic [7:0]  rd;
        logic [7:0]  wr;
    } dbt_row_s;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    dbt_avs_s    avs = '0;
    logic        o_avs_waitrequest;
    logic [31:0] o_avs_readdata;
    logic [31:0] irq = 32'h0000_0000;
    logic        wait_req;
    logic        cpu_done;
    dbt_bus_s    o_bus;
    logic        o_cpu_owns_bus;
    logic [3:0]  stall = 4'h0;
    logic [3:0]  cpu_len = 4'h1;
    logic        ce = 1'b1;
    logic [31:0] q;
    int          n_mismatch = 0;
    int          check_count = 0;
    int          rd, wr, gap, nt, wd, sc;
    logic        prev;
    logic [1:0]  order [$];
    always #12.5 i_clk = ~i_clk;
    dbt_top dut (.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .i_avs(avs),
        .o_avs_waitrequest(o_avs_waitrequest), .o_avs_readdata(o_avs_readdata),
        .i_periph_irq(irq), .i_wait_req(wait_req), .i_cpu_done(cpu_done),
        .o_bus(o_bus), .o_cpu_owns_bus(o_cpu_owns_bus));
    dbt_cpu_model cpu (.i_clk(i_clk), .i_rst(i_rst), .i_bus(o_bus),
        .i_cpu_owns_bus(o_cpu_owns_bus), .i_stall(stall), .i_cpu_len(cpu_len),
        .o_cpu_done(cpu_done), .o_wait_req(wait_req));
    function automatic logic [31:0] chv(logic w, logic [1:0] sc, logic [1:0] sr,
        logic so, logic [1:0] dc, logic [1:0] dr, logic dd);
        return {14'h0000, dd, dr, dc, so, sr, sc, 1'b1, w, 6'h00};
    endfunction : chv
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic report_and_stop();
        if (n_mismatch == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : report_and_stop
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge i_clk);
        avs <= '{read: !w, write: w, address: a, writedata: d, byteenable: 4'hF};
        do begin
            @(posedge i_clk);
        end while (o_avs_waitrequest !== 1'b0);
        q = o_avs_readdata;
        avs.read <= 1'b0;
        avs.write <= 1'b0;
    endtask : bus
    task automatic xfer(input logic [31:0] ch);
        int n;
        n = 0;
        rd = 0;
        wr = 0;
        wd = 0;
        sc = 0;
        bus(1'b1, OFS_CH0, ch | 32'h0000_0020);
        while (o_bus.own !== 1'b1 && n < 40) begin
            @(posedge i_clk);
            n++;
        end
        while (o_bus.own === 1'b1 && n < 80) begin
            if (o_bus.wr === 1'b1) wr++;
            else rd += (wr > 0) ? 100 : 1;
            wd += (o_bus.word === 1'b1);
            sc += (o_bus.second === 1'b1);
            @(posedge i_clk);
            n++;
        end
    endtask : xfer
    dbt_row_s rows [10] = '{
        '{chv(0, 0, 0, 0, 0, 0, 0), 12'h0F0, 16'h2222, 8'h01, 8'h01},
        '{chv(1, 0, 0, 0, 0, 0, 0), 12'h0F0, 16'h2222, 8'h01, 8'h01},
        '{chv(1, 0, 0, 1, 0, 0, 0), 12'h0F0, 16'h2222, 8'h02, 8'h01},
        '{chv(0, 2, 0, 1, 1, 0, 1), 12'h0F0, 16'h2222, 8'h02, 8'h02},
        '{chv(1, 3, 0, 0, 0, 0, 0), 12'h0E1, 16'h2222, 8'h04, 8'h01},
        '{chv(1, 0, 0, 0, 3, 1, 0), 12'h0D1, 16'h2222, 8'h01, 8'h04},
        '{chv(1, 3, 0, 0, 0, 0, 0), 12'h1F1, 16'h2222, 8'h03, 8'h01},
        '{chv(1, 3, 0, 0, 0, 0, 0), 12'h0E0, 16'h2222, 8'h02, 8'h01},
        '{chv(1, 3, 2, 0, 3, 3, 1), 12'h0F1, 16'h2922, 8'h09, 8'h04},
        '{chv(0, 3, 0, 1, 0, 0, 0), 12'h0E1, 16'h2222, 8'h02, 8'h01}
    };
    initial begin
        #500000;
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        bus(1'b0, OFS_CFG, 32'h0000_0000);
        chk("cfg", q, 32'h0000_00F0);
        bus(1'b0, OFS_EXTCYC, 32'h0000_0000);
        chk("extcyc", q, 32'h0000_2222);
        bus(1'b0, 6'h1C, 32'h0000_0000);
        chk("unmapped", q, 32'h0000_0000);
        chk("cpu_owns", {31'h0, o_cpu_owns_bus}, 32'h0000_0001);
        foreach (rows[i]) begin
            bus(1'b1, OFS_CFG, {20'h0_0000, rows[i].cfg});
            bus(1'b1, OFS_EXTCYC, {16'h0000, rows[i].ext});
            xfer(rows[i].ch);
            chk("read_cycles", 32'(rd), 32'(rows[i].rd));
            chk("write_cycles", 32'(wr), 32'(rows[i].wr));
            bus(1'b0, OFS_STAT, 32'h0000_0000);
            chk("last", {24'h0, q[15:8]}, 32'(rows[i].rd + rows[i].wr));
        end
        stall <= 4'h2;
        bus(1'b1, OFS_CFG, 32'h0000_00E1);
        xfer(rows[4].ch);
        chk("stall_read", 32'(rd), 32'h0000_0006);
        bus(1'b0, OFS_STAT, 32'h0000_0000);
        chk("stall_last", {24'h0, q[15:8]}, 32'h0000_0005);
        xfer(rows[0].ch);
        chk("ram_nostall", 32'(rd), 32'h0000_0001);
        stall <= 4'h0;
        cpu_len <= 4'h3;
        for (int c = 0; c < NCH; c++) bus(1'b1, 6'(4 * c), chv(0, 0, 0, 0, 0, 0, 0) | 32'(c + 1));
        @(posedge i_clk);
        irq <= 32'h0000_001E;
        @(posedge i_clk);
        irq <= 32'h0000_0004;
        @(posedge i_clk);
        irq <= 32'h0000_0000;
        prev = 1'b0;
        gap = 100;
        repeat (150) begin
            @(posedge i_clk);
            if (o_bus.own === 1'b1 && !prev) begin
                order.push_back(o_bus.ch);
                chk("handback_gap", 32'(gap > 3), 32'h0000_0001);
            end
            gap = (o_bus.own === 1'b1) ? 0 : gap + 1;
            prev = (o_bus.own === 1'b1);
        end
        chk("grants", 32'(order.size()), 32'h0000_0004);
        foreach (order[i]) chk("order", {30'h0, order[i]}, 32'(i));
        bus(1'b1, OFS_CH0, 32'h0000_0001);
        ce <= 1'b0;
        irq <= 32'h0000_0006;
        @(posedge i_clk);
        irq <= 32'h0000_0000;
        nt = 0;
        repeat (20) begin
            @(posedge i_clk);
            ce <= 1'b1;
            nt += (o_bus.own !== 1'b0);
        end
        chk("disabled_idle", 32'(nt), 32'h0000_0000);
        bus(1'b1, OFS_EXTCYC, 32'h0000_2922);
        xfer(rows[8].ch | 32'h0000_0080);
        chk("ext_read", 32'(rd), 32'h0000_0009);
        chk("ext_write", 32'(wr), 32'h0000_0004);
        chk("word_cycles", 32'(wd), 32'h0000_0009);
        chk("second_cycles", 32'(sc), 32'h0000_0002);
        i_rst <= 1'b1;
        @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        chk("reset_own", {31'h0, o_bus.own}, 32'h0000_0000);
        bus(1'b0, OFS_EXTCYC, 32'h0000_0000);
        chk("reset_ext", q, 32'h0000_2222);
        bus(1'b0, OFS_CFG, 32'h0000_0000);
        chk("reset_cfg", q, 32'h0000_00F0);
        report_and_stop();
    end
endmodule : dbt_top_test
